/* File: logic/tco_map.svh */
// register offsets, reset values and field widths of the channel output control block
`ifndef TCO_MAP_SVH
`define TCO_MAP_SVH

`define TCO_NUM_CH          8
`define TCO_ADDR_W          5

`define TCO_OFS_LEVELS      5'h00
`define TCO_OFS_ENABLES     5'h04
`define TCO_OFS_MODE        5'h08
`define TCO_OFS_POLARITY    5'h0C
`define TCO_OFS_START_SEL   5'h10
`define TCO_OFS_MASTER_EN   5'h14
`define TCO_OFS_IRQ_STAT    5'h18
`define TCO_OFS_IRQ_MASK    5'h1C

`define TCO_RST_LEVELS      8'h00
`define TCO_RST_ENABLES     8'h00
`define TCO_RST_MODE        8'h00
`define TCO_RST_POLARITY    8'h00
`define TCO_RST_START_SEL   8'h00
`define TCO_RST_MASTER_EN   8'h01
`define TCO_RST_IRQ_MASK    8'h00

// channels that may be masters: 0, 2, 4, 6
`define TCO_MASTER_CAPABLE  8'h55

`endif

/* File: logic/tco_pkg.sv */
// types shared by the channel output control block
package tco_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } tco_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } tco_avs_rsp_t;

    typedef struct packed {
        logic [7:0] cnt_irq;
        logic [7:0] cnt_start;
        logic [7:0] count_tick;
        logic [7:0] start_capable;
    } tco_timer_ev_t;

    typedef struct packed {
        logic [7:0]  levels;
        logic [7:0]  enables;
        logic [7:0]  mode;
        logic [7:0]  polarity;
        logic [7:0]  start_sel;
        logic [7:0]  master_en;
        logic [7:0]  set_pend;
        logic [7:0]  irq_stat;
        logic [7:0]  irq_mask;
        logic [7:0]  chan_irq;
        logic        ack;
        logic [31:0] rdata;
    } tco_state_t;

endpackage : tco_pkg

/* File: logic/tco_output_ctrl.sv */
// channel output latches of an eight-channel timer unit, with avalon-mm register access
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "tco_map.svh"

module tco_output_ctrl (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire tco_pkg::tco_avs_req_t avs_req,
    output      tco_pkg::tco_avs_rsp_t avs_rsp,
    input  wire tco_pkg::tco_timer_ev_t timer_ev,
    output      logic [7:0]            channel_output_bit,
    output      logic [7:0]            master_count_irq,
    output      logic                  irq
);
    import tco_pkg::*;

    localparam int NCH = `TCO_NUM_CH;

    tco_state_t s_r;
    tco_state_t s_nxt;

    logic [7:0] chan_evt;
    logic [7:0] master_eff;
    logic       req;
    logic       wr_go;
    logic       be0;

    assign req   = avs_req.read | avs_req.write;
    assign wr_go = avs_req.write & s_r.ack;
    assign be0   = avs_req.byteenable[0];

    // counter outputs are same-clock logic, so no synchroniser is needed here
    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            chan_evt[n] = timer_ev.cnt_irq[n]
                        | (timer_ev.cnt_start[n] & s_r.start_sel[n]
                           & timer_ev.start_capable[n]);
        end
        master_eff = s_r.master_en & `TCO_MASTER_CAPABLE;
        master_eff[0] = 1'b1;
    end

    always_comb begin
        logic [2:0] mi;
        logic       has_m;
        logic       apply_set;
        logic [7:0] wdat;
        mi        = 3'h0;
        has_m     = 1'b0;
        apply_set = 1'b0;
        wdat      = avs_req.writedata[7:0];
        s_nxt     = s_r;

        // one wait state: first cycle latches read data, second releases the master
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack) begin
            unique case (avs_req.address)
                `TCO_OFS_LEVELS:    s_nxt.rdata = {24'h000000, s_r.levels};
                `TCO_OFS_ENABLES:   s_nxt.rdata = {24'h000000, s_r.enables};
                `TCO_OFS_MODE:      s_nxt.rdata = {24'h000000, s_r.mode};
                `TCO_OFS_POLARITY:  s_nxt.rdata = {24'h000000, s_r.polarity};
                `TCO_OFS_START_SEL: s_nxt.rdata = {24'h000000, s_r.start_sel};
                `TCO_OFS_MASTER_EN: s_nxt.rdata = {24'h000000, master_eff};
                `TCO_OFS_IRQ_STAT:  s_nxt.rdata = {24'h000000, s_r.irq_stat};
                `TCO_OFS_IRQ_MASK:  s_nxt.rdata = {24'h000000, s_r.irq_mask};
                default:            s_nxt.rdata = 32'h00000000;
            endcase
        end

        // configuration writes; none of them touch the counters
        if (wr_go && be0) begin
            unique case (avs_req.address)
                `TCO_OFS_ENABLES:   s_nxt.enables   = wdat;
                `TCO_OFS_MODE:      s_nxt.mode      = wdat;
                `TCO_OFS_POLARITY:  s_nxt.polarity  = wdat;
                `TCO_OFS_START_SEL: s_nxt.start_sel = wdat;
                `TCO_OFS_MASTER_EN: s_nxt.master_en = wdat & `TCO_MASTER_CAPABLE;
                `TCO_OFS_IRQ_MASK:  s_nxt.irq_mask  = wdat;
                default:            ;
            endcase
        end

        for (int p = 0; p < NCH; p++) begin
            // nearest master below p; a master itself has no set source
            has_m = 1'b0;
            mi    = 3'h0;
            for (int m = 0; m < p; m++) begin
                if (master_eff[m]) begin
                    has_m = 1'b1;
                    mi    = 3'(m);
                end
            end
            if (master_eff[p]) begin
                has_m = 1'b0;
            end

            apply_set = s_r.set_pend[p] & timer_ev.count_tick[p];

            if (!s_r.enables[p]) begin
                // interrupts are kept off the latch, software owns the bit
                s_nxt.set_pend[p] = 1'b0;
                if (wr_go && be0 && avs_req.address == `TCO_OFS_LEVELS) begin
                    s_nxt.levels[p] = wdat[p];
                end
            end else if (!s_r.mode[p]) begin
                s_nxt.set_pend[p] = 1'b0;
                if (chan_evt[p]) begin
                    s_nxt.levels[p] = ~s_r.levels[p];
                end
            end else begin
                // set from master is held until the follower's next count clock
                s_nxt.set_pend[p] = (s_r.set_pend[p] & ~timer_ev.count_tick[p])
                                  | (has_m & chan_evt[mi]);
                if (chan_evt[p]) begin
                    s_nxt.levels[p] = s_r.polarity[p];
                end else if (apply_set) begin
                    s_nxt.levels[p] = ~s_r.polarity[p];
                end
            end
        end

        // sticky status: a new event in the clearing cycle keeps its bit
        s_nxt.irq_stat = s_r.irq_stat;
        if (wr_go && be0 && avs_req.address == `TCO_OFS_IRQ_STAT) begin
            s_nxt.irq_stat = s_r.irq_stat & ~wdat;
        end
        s_nxt.irq_stat = s_nxt.irq_stat | chan_evt;
        s_nxt.chan_irq = chan_evt;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r           <= '0;
            s_r.levels    <= `TCO_RST_LEVELS;
            s_r.enables   <= `TCO_RST_ENABLES;
            s_r.mode      <= `TCO_RST_MODE;
            s_r.polarity  <= `TCO_RST_POLARITY;
            s_r.start_sel <= `TCO_RST_START_SEL;
            s_r.master_en <= `TCO_RST_MASTER_EN;
            s_r.irq_mask  <= `TCO_RST_IRQ_MASK;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_rsp.waitrequest = req & ~s_r.ack;
    assign avs_rsp.readdata    = s_r.rdata;
    assign channel_output_bit  = s_r.levels;
    assign master_count_irq    = s_r.chan_irq;
    assign irq                 = |(s_r.irq_stat & s_r.irq_mask);

endmodule : tco_output_ctrl

/* File: testbench/tco_output_ctrl_assertions.sv */
// port checker of the channel output control block
`timescale 1ns/100ps
`include "tco_map.svh"
module tco_output_ctrl_chk (
    input wire logic                   ref_clk,
    input wire logic                   arst_n,
    input wire tco_pkg::tco_avs_req_t  avs_req,
    input wire tco_pkg::tco_avs_rsp_t  avs_rsp,
    input wire tco_pkg::tco_timer_ev_t timer_ev,
    input wire logic [7:0]             channel_output_bit,
    input wire logic [7:0]             master_count_irq,
    input wire logic                   irq
);
    import tco_pkg::*;
    logic rq;
    logic ok;
    assign rq = avs_req.read | avs_req.write;
    assign ok = rq & ~avs_rsp.waitrequest;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    one_wait_a: assert property (rq && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
        else $error("bus answer not after one wait state");
    idle_ready_a: assert property (!rq |-> !avs_rsp.waitrequest) else $error("idle wait");
    high_zero_a: assert property (avs_req.read && ok |-> avs_rsp.readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    hole_read_a: assert property (avs_req.read && ok && avs_req.address[1:0] != 2'h0
        |-> avs_rsp.readdata == 32'h0) else $error("unmapped read not zero");
    level_read_a: assert property (avs_req.read && ok && avs_req.address == `TCO_OFS_LEVELS
        |-> avs_rsp.readdata[7:0] == $past(channel_output_bit)) else $error("level read");
    irq_pulse_a: assert property (timer_ev.cnt_irq[0] |=> master_count_irq[0])
        else $error("channel interrupt missing");
    start_quiet_a: assert property (timer_ev.cnt_start[0] && !timer_ev.start_capable[0]
        && !timer_ev.cnt_irq[0] |=> !master_count_irq[0]) else $error("start irq raised");
    latch_cause_a: assert property ($changed(channel_output_bit[0]) |->
        $past(timer_ev.cnt_irq[0] | timer_ev.cnt_start[0] | (ok & avs_req.write)))
        else $error("output latch changed without cause");
    irq_cause_a: assert property ($rose(irq) |-> (|master_count_irq) ||
        $past(|master_count_irq) || $past(ok && avs_req.write)) else $error("irq rose");
endmodule : tco_output_ctrl_chk
bind tco_output_ctrl tco_output_ctrl_chk u_chk (.ref_clk, .arst_n, .avs_req, .avs_rsp,
    .timer_ev, .channel_output_bit, .master_count_irq, .irq);

/* File: testbench/tco_output_ctrl_bench.sv */
// self-checking bench of the channel output control block
`timescale 1ns/100ps
`include "tco_map.svh"
module tco_output_ctrl_bench;
    import tco_pkg::*;
    logic          ref_clk = 1'b0;
    logic          arst_n  = 1'b0;
    tco_avs_req_t  req     = '0;
    tco_avs_rsp_t  rsp;
    tco_timer_ev_t ev      = '0;
    logic [7:0]    lvl, mci;
    logic          irq;
    logic [31:0]   rd, r, seed = 32'h0000000D;
    int            err_total = 0, num_checks = 0, cyc = 0;
    tco_output_ctrl dut (.ref_clk, .arst_n, .avs_req(req), .avs_rsp(rsp), .timer_ev(ev),
        .channel_output_bit(lvl), .master_count_irq(mci), .irq);
    initial forever #50 ref_clk = ~ref_clk;
    // the whole run needs well under this many cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{!w, w, a, {24'h0, d}, 4'hF};
        do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req <= '0;
    endtask : bus
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rdc
    task automatic pulse(input logic [7:0] i, s, t, c);
        @(posedge ref_clk);
        ev <= '{i, s, t, c};
        @(posedge ref_clk);
        ev <= '0;
        repeat (2) @(posedge ref_clk);
    endtask : pulse
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(5'(i * 4), i == 5 ? `TCO_RST_MASTER_EN : 8'h00);
        rdc(5'h06, 8'h00);
        $display("reset test done");
        for (int k = 0; k < 6; k++) begin
            r = xs();
            bus(1'b1, 5'h04, 8'h00);
            bus(1'b1, 5'h00, r[7:0]);
            bus(1'b1, 5'h04, r[15:8]);
            bus(1'b1, 5'h00, r[23:16]);
            rdc(5'h00, (r[7:0] & r[15:8]) | (r[23:16] & ~r[15:8]));
        end
        bus(1'b1, 5'h04, 8'h00);
        bus(1'b1, 5'h00, 8'h01);
        bus(1'b1, 5'h0C, 8'hFF);
        pulse(8'h01, 8'h00, 8'h00, 8'h00);
        rdc(5'h00, 8'h01);
        bus(1'b1, 5'h04, 8'h01);
        pulse(8'h01, 8'h00, 8'h00, 8'h00);
        rdc(5'h00, 8'h00);
        $display("master test done");
        bus(1'b1, 5'h0C, 8'h00);
        bus(1'b1, 5'h08, 8'h02);
        bus(1'b1, 5'h04, 8'h02);
        pulse(8'h01, 8'h00, 8'h02, 8'h00);
        rdc(5'h00, 8'h00);
        pulse(8'h00, 8'h00, 8'h02, 8'h00);
        rdc(5'h00, 8'h02);
        pulse(8'h02, 8'h00, 8'h00, 8'h00);
        rdc(5'h00, 8'h00);
        pulse(8'h01, 8'h00, 8'h00, 8'h00);
        pulse(8'h02, 8'h00, 8'h02, 8'h00);
        rdc(5'h00, 8'h00);
        bus(1'b1, 5'h0C, 8'h02);
        rdc(5'h00, 8'h00);
        pulse(8'h02, 8'h00, 8'h00, 8'h00);
        rdc(5'h00, 8'h02);
        $display("follower test done");
        bus(1'b1, 5'h04, 8'h03);
        bus(1'b1, 5'h10, 8'h01);
        pulse(8'h00, 8'h01, 8'h00, 8'h01);
        rdc(5'h00, 8'h03);
        pulse(8'h00, 8'h01, 8'h00, 8'h00);
        rdc(5'h00, 8'h03);
        bus(1'b1, 5'h10, 8'h00);
        pulse(8'h00, 8'h01, 8'h00, 8'h01);
        rdc(5'h00, 8'h03);
        $display("start test done");
        bus(1'b1, 5'h18, 8'hFF);
        bus(1'b1, 5'h1C, 8'h01);
        // irq is looked at half a cycle on, once the write has settled
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        pulse(8'h01, 8'h00, 8'h00, 8'h00);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 5'h1C, 8'h00);
        @(negedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 5'h18, 8'h01);
        rdc(5'h18, 8'h00);
        bus(1'b1, 5'h14, 8'hFF);
        rdc(5'h14, `TCO_MASTER_CAPABLE);
        $display("interrupt test done");
        test_done();
    end
endmodule : tco_output_ctrl_bench
